// *** hw/dsp_pkg.sv ***
package dsp_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_BUF = 3'h1;
    localparam logic [2:0] ADDR_STATION_ADDRESS = 3'h2;
    localparam logic [2:0] ADDR_SMASK = 3'h3;
    localparam logic [2:0] ADDR_PWR = 3'h4;
    localparam logic [2:0] ADDR_BAUD = 3'h5;
    // serial_control bit positions
    localparam int B_RXDONE = 0;
    localparam int B_TXDONE = 1;
    localparam int B_RX9 = 2;
    localparam int B_TX9 = 3;
    localparam int B_REN = 4;
    localparam int B_AFE = 5;
    localparam int B_MLO = 6;
    localparam int B_MHI = 7;
    // power_control_reg bit positions
    localparam int B_FEVIEW = 6;
    localparam int B_DOUBLE = 7;
    // baud source bits
    localparam int B_TXSRC = 0;
    localparam int B_RXSRC = 1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // fixed dividers
    localparam int DIV_M0 = 12;
    localparam int DIV_M2_SLOW = 64;
    localparam int DIV_M2_FAST = 32;
    localparam int OVS = 16;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [3:0] BITS_10 = 4'hA;
    localparam logic [3:0] BITS_11 = 4'hB;

    typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9F, MODE_UART9V} dsp_mode_e;
    typedef enum {TX_IDLE, TX_RUN} dsp_txst_e;
    typedef enum {RX_IDLE, RX_RUN} dsp_rxst_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } dsp_bus_s;
endpackage

// *** hw/dsp_serial_port.sv ***
// Overview of operation
// - one address: writes fill transmit buffer, reads return receive buffer.
// - mode 0 shifts 8 bits LSB first with shift clock at osc/12.
// - mode 1 frame is start, 8 data, stop; stop bit stored in rx_ninth_bit.
// - modes 2/3 send tx_ninth_bit as ninth bit and capture it to rx_ninth_bit.
// - mode 2 bit rate is osc/64, or osc/32 with baud_double_select.
// - mode 3 equals mode 2 but bit rate comes from timer overflow.
// - any write to the buffer address starts a transmission.
// - mode 0 reception starts when receive_done_flag is 0 and receive_enable is 1.
// - modes 1-3 reception starts on falling start edge while receive_enable set.
// - control bit 7 is frame_error_flag if view select set, else mode_select_high.
// - bad stop bit sets frame_error_flag; only software clears it.
// - mode select bits 00,01,10,11 choose modes 0,1,2,3.
// - modes 2/3 with filter: done only if ninth bit 1 and address matches.
// - mode 1 with filter: done only if stop bit valid and address matches.
// - reception only while receive_enable is 1.
// - transmit_done_flag set by hardware at end of frame, held until written.
// - receive_done_flag set at end of reception, subject to address filter.
// - compare byte uses address bits where mask is 1, others don't care; a byte with 1 in every bit set in address or mask also matches.
// - address recognition applies in modes 1-3 only.
// - station address and mask are readable and writable.
// - interrupt request is transmit_done_flag OR receive_done_flag.
// - modes 1/3 pick tx/rx bit clock from second timer when source select is 1.
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port
    import dsp_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    input wire logic sys_clk_i, // 200 MHz
    input wire logic rst_i, // async, active high
    input wire logic [2:0] addr_i, // register index
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after strobe
    input wire logic timer1_ovf_i, // first timer overflow pulse
    input wire logic timer2_ovf_i, // second timer overflow pulse
    input wire logic rxd_i, // data pin input
    output logic rxd_o, // data pin output (mode 0)
    output logic rxd_oe_o, // data pin enable
    output logic txd_o, // serial out / shift clock
    output logic irq_o // serial interrupt request
);
    dsp_bus_s bus;
    assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    logic mhi_r, mlo_r, afe_r, ren_r, tx9_r, rx9_r, txd_r, rxdn_r, fe_r;
    logic feview_r, dbl_r, txsrc_r, rxsrc_r;
    logic [7:0] rxbuf_r, station_address_r, smask_r, rdata_r;
    dsp_mode_e mode;
    assign mode = dsp_mode_e'({mhi_r, mlo_r});

    // three-stage synchroniser; stage 0 read only by stage 1
    logic [2:0] rx_sync_r;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_sync_r <= 3'h7;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], rxd_i};
        end
    end
    logic rx_lvl_r;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_lvl_r <= 1'b1;
        end else if (rx_sync_r[1] == rx_sync_r[2]) begin
            rx_lvl_r <= rx_sync_r[2];
        end
    end

    // tick12 marks each half of the osc/12 shift clock; tick_m2 is the
    // 16x sample tick of mode 2, so one bit lasts 32 or 64 clocks
    logic [3:0] div12_r;
    logic [5:0] div64_r;
    logic tick12, tick_m2;
    assign tick12 = (div12_r == 4'((DIV_M0 / 2) - 1));
    assign tick_m2 = dbl_r ? (div64_r == 6'((DIV_M2_FAST / OVS) - 1))
                           : (div64_r == 6'((DIV_M2_SLOW / OVS) - 1));
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div12_r <= 4'h0;
            div64_r <= 6'h00;
        end else begin
            div12_r <= tick12 ? 4'h0 : div12_r + 4'h1;
            div64_r <= tick_m2 ? 6'h00 : div64_r + 6'h01;
        end
    end

    // modes 1 and 3 take their 16x sample tick from a timer overflow
    function automatic logic pick_tick(input dsp_mode_e m, input logic src, input logic m2t);
        case (m)
            MODE_UART9F: pick_tick = m2t;
            default: pick_tick = src ? timer2_ovf_i : timer1_ovf_i;
        endcase
    endfunction
    logic tx_os, rx_os;
    assign tx_os = pick_tick(mode, txsrc_r, tick_m2);
    assign rx_os = pick_tick(mode, rxsrc_r, tick_m2);

    // address match
    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
        logic [7:0] bc;
        bc = a | m;
        addr_hit = (((b ^ a) & m) == 8'h00) || (((b ^ bc) & bc) == 8'h00);
    endfunction

    // transmitter
    dsp_txst_e tx_st;
    logic [10:0] tx_sh_r;
    logic [3:0] tx_cnt_r, tx_os_r;
    logic tx_clk_r, tx_out_r, tx_fin;
    logic [3:0] tx_len;
    // mode 0 spends its first falling edge on a dummy bit so d0 stands before the first rise
    assign tx_len = (mode == MODE_SHIFT) ? BITS_9 : (mode == MODE_UART8) ? BITS_10 : BITS_11;
    logic tx_step;
    assign tx_step = (mode == MODE_SHIFT) ? (tick12 && tx_clk_r) : (tx_os && tx_os_r == OVS_LAST);
    assign tx_fin = (tx_st == TX_RUN) && tx_step && (tx_cnt_r == tx_len - 4'h1);
    logic buf_wr;
    assign buf_wr = bus.wr && bus.addr == ADDR_BUF;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st <= TX_IDLE;
            tx_sh_r <= 11'h7FF;
            tx_cnt_r <= 4'h0;
            tx_os_r <= 4'h0;
            tx_clk_r <= 1'b1;
        end else if (buf_wr) begin
            tx_st <= TX_RUN;
            tx_cnt_r <= 4'h0;
            tx_os_r <= 4'h0;
            tx_clk_r <= 1'b1;
            if (mode == MODE_SHIFT) begin
                tx_sh_r <= {2'h3, bus.wdata, 1'b1};
            end else if (mode == MODE_UART8) begin
                tx_sh_r <= {2'h3, bus.wdata, 1'b0};
            end else begin
                tx_sh_r <= {1'b1, tx9_r, bus.wdata, 1'b0};
            end
        end else if (tx_st == TX_RUN) begin
            if (mode == MODE_SHIFT) begin
                if (tick12) begin
                    tx_clk_r <= ~tx_clk_r;
                end
            end else if (tx_os) begin
                tx_os_r <= tx_os_r + 4'h1;
            end
            if (tx_step) begin
                tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                tx_cnt_r <= tx_cnt_r + 4'h1;
                if (tx_fin) begin
                    tx_st <= TX_IDLE;
                end
            end
        end
    end

    // receiver
    dsp_rxst_e rx_st;
    logic [9:0] rx_sh_r;
    logic [3:0] rx_cnt_r, rx_os_r;
    logic rx_prev_r, rx_clk_r, rx_fin, rx_fe_ev, rx_set;
    logic [3:0] rx_len;
    assign rx_len = (mode == MODE_UART8) ? BITS_9 : (mode == MODE_SHIFT) ? (BITS_8 - 4'h1) : BITS_10;
    logic rx_start;
    assign rx_start = (rx_st == RX_IDLE) && ren_r &&
        ((mode == MODE_SHIFT) ? !rxdn_r
                              : (rx_prev_r && !rx_lvl_r));
    logic rx_samp;
    assign rx_samp = (mode == MODE_SHIFT) ? (tick12 && !rx_clk_r) : (rx_os && rx_os_r == OVS_MID);
    assign rx_fin = (rx_st == RX_RUN) && rx_samp && (rx_cnt_r == rx_len);
    logic [7:0] rx_byte;
    logic rx_stop, rx_bit9;
    // rx_sh_r holds most recent bit at top; frame shifted in LSB first
    always_comb begin
        rx_byte = 8'h00;
        rx_stop = rx_lvl_r;
        rx_bit9 = rx_lvl_r;
        case (mode)
            MODE_SHIFT: rx_byte = {rx_lvl_r, rx_sh_r[9:3]};
            MODE_UART8: rx_byte = rx_sh_r[9:2];
            default: begin
                rx_byte = rx_sh_r[8:1];
                rx_bit9 = rx_sh_r[9];
            end
        endcase
    end
    assign rx_fe_ev = rx_fin && (mode != MODE_SHIFT) && !rx_stop;
    always_comb begin
        case (mode)
            MODE_SHIFT: rx_set = rx_fin;
            MODE_UART8: rx_set = rx_fin && (!afe_r || (rx_stop && addr_hit(rx_byte, station_address_r, smask_r)));
            default: rx_set = rx_fin && (!afe_r || (rx_bit9 && addr_hit(rx_byte, station_address_r, smask_r)));
        endcase
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st <= RX_IDLE;
            rx_sh_r <= 10'h000;
            rx_cnt_r <= 4'h0;
            rx_os_r <= 4'h0;
            rx_prev_r <= 1'b1;
            rx_clk_r <= 1'b1;
        end else begin
            rx_prev_r <= rx_lvl_r;
            if (rx_start) begin
                rx_st <= RX_RUN;
                rx_cnt_r <= 4'h0;
                rx_os_r <= 4'h0;
                rx_clk_r <= 1'b1;
            end else if (rx_st == RX_RUN) begin
                if (!ren_r) begin
                    rx_st <= RX_IDLE;
                end else begin
                    if (mode == MODE_SHIFT) begin
                        if (tick12) begin
                            rx_clk_r <= ~rx_clk_r;
                        end
                    end else if (rx_os) begin
                        rx_os_r <= rx_os_r + 4'h1;
                    end
                    if (rx_samp) begin
                        rx_sh_r <= {rx_lvl_r, rx_sh_r[9:1]};
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        // a start bit that is no longer low is a glitch
                        if (mode != MODE_SHIFT && rx_cnt_r == 4'h0 && rx_lvl_r) begin
                            rx_st <= RX_IDLE;
                        end
                        if (rx_fin) begin
                            rx_st <= RX_IDLE;
                        end
                    end
                end
            end
        end
    end

    // control and flag registers; hardware set wins over software clear
    logic ctrl_wr;
    assign ctrl_wr = bus.wr && bus.addr == ADDR_CTRL;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {mhi_r, mlo_r, afe_r, ren_r, tx9_r} <= CTRL_RST[7:3];
            fe_r <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                if (!feview_r) begin
                    mhi_r <= bus.wdata[B_MHI];
                end
                mlo_r <= bus.wdata[B_MLO];
                afe_r <= bus.wdata[B_AFE];
                ren_r <= bus.wdata[B_REN];
                tx9_r <= bus.wdata[B_TX9];
            end
            if (rx_fe_ev) begin
                fe_r <= 1'b1;
            end else if (ctrl_wr && feview_r) begin
                fe_r <= bus.wdata[B_MHI];
            end
        end
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_r <= 1'b0;
            rxdn_r <= 1'b0;
            rx9_r <= 1'b0;
            rxbuf_r <= BYTE_RST;
        end else begin
            if (tx_fin) begin
                txd_r <= 1'b1;
            end else if (ctrl_wr) begin
                txd_r <= bus.wdata[B_TXDONE];
            end
            if (rx_set) begin
                rxdn_r <= 1'b1;
                rxbuf_r <= rx_byte;
                if (mode != MODE_SHIFT) begin
                    rx9_r <= (mode == MODE_UART8) ? rx_stop : rx_bit9;
                end
            end else if (ctrl_wr) begin
                rxdn_r <= bus.wdata[B_RXDONE];
                rx9_r <= bus.wdata[B_RX9];
            end
        end
    end

    // address, mask, power and baud source registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            station_address_r <= BYTE_RST;
            smask_r <= BYTE_RST;
            feview_r <= 1'b0;
            dbl_r <= 1'b0;
            txsrc_r <= 1'b0;
            rxsrc_r <= 1'b0;
        end else if (bus.wr) begin
            case (bus.addr)
                ADDR_STATION_ADDRESS: station_address_r <= bus.wdata;
                ADDR_SMASK: smask_r <= bus.wdata;
                ADDR_PWR: begin
                    feview_r <= bus.wdata[B_FEVIEW];
                    dbl_r <= bus.wdata[B_DOUBLE];
                end
                ADDR_BAUD: begin
                    txsrc_r <= bus.wdata[B_TXSRC];
                    rxsrc_r <= bus.wdata[B_RXSRC];
                end
                default: ;
            endcase
        end
    end

    // read port; unmapped indices read zero
    logic [7:0] ctrl_view;
    assign ctrl_view = {feview_r ? fe_r : mhi_r, mlo_r, afe_r, ren_r, tx9_r, rx9_r, txd_r, rxdn_r};
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL: rdata_r <= ctrl_view;
                ADDR_BUF: rdata_r <= rxbuf_r;
                ADDR_STATION_ADDRESS: rdata_r <= station_address_r;
                ADDR_SMASK: rdata_r <= smask_r;
                ADDR_PWR: rdata_r <= {dbl_r, feview_r, 6'h00};
                ADDR_BAUD: rdata_r <= {6'h00, rxsrc_r, txsrc_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata_o = rdata_r;

    // pin drive: mode 0 drives data on rxd while transmitting, clock on txd
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_out_r <= 1'b1;
        end else if (tx_st == TX_RUN && mode == MODE_SHIFT) begin
            tx_out_r <= tx_clk_r;
        end else if (tx_st == TX_RUN) begin
            tx_out_r <= tx_sh_r[0];
        end else if (rx_st == RX_RUN && mode == MODE_SHIFT) begin
            tx_out_r <= rx_clk_r;
        end else begin
            tx_out_r <= 1'b1;
        end
    end
    assign txd_o = tx_out_r;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
        end else begin
            rxd_o <= tx_sh_r[0];
            rxd_oe_o <= (tx_st == TX_RUN) && (mode == MODE_SHIFT);
        end
    end
    assign irq_o = txd_r | rxdn_r;

    // checks
    AST_TX_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        tx_fin |=> txd_r) else $error("transmit done not set");
    AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_o == (txd_r | rxdn_r)) else $error("irq mismatch");
    AST_TX_START: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        buf_wr |=> tx_st == TX_RUN) else $error("write did not start transmit");
    AST_FE_STICKY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fe_r && !(ctrl_wr && feview_r) |=> fe_r) else $error("frame error cleared by hardware");
    AST_REN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !ren_r |=> rx_st == RX_IDLE) else $error("reception while disabled");
    AST_FILTER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rx_fin && afe_r && mode != MODE_SHIFT && mode != MODE_UART8 && !rx_bit9 |=> !$rose(rxdn_r))
        else $error("filtered frame set receive done");
    AST_MODE0: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mode == MODE_SHIFT && ren_r && !rxdn_r && rx_st == RX_IDLE |=> rx_st == RX_RUN)
        else $error("mode 0 reception did not start");
    // mode 0 data must already stand when the shift clock rises
    sequence shift_clk_rise;
        rxd_oe_o && $rose(txd_o);
    endsequence
    AST_SHIFT_DATA: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        shift_clk_rise |-> $stable(rxd_o)) else $error("shift data moved on clock rise");
    AST_CTRL7: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        bus.rd && bus.addr == ADDR_CTRL |=> rdata_o[B_MHI] == ($past(feview_r) ? $past(fe_r) : $past(mhi_r)))
        else $error("control bit 7 view wrong");
endmodule
`default_nettype wire

// *** sim/dsp_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsp_peer (
    input wire logic clk_i, // bench clock
    input wire logic line_i, // serial out or shift clock of the port
    input wire logic data_i, // resolved data pin level
    output logic drv_o, // level driven onto the data pin
    output logic drv_en_o // high while the peer drives the data pin
);
    initial begin
        drv_o = 1'b1;
        drv_en_o = 1'b0;
    end

    // bits go out LSB first, each held len clocks
    task automatic send(input logic [10:0] bits, input int n, input int len);
        drv_en_o <= 1'b1;
        for (int i = 0; i < n; i++) begin
            drv_o <= bits[i];
            repeat (len) @(posedge clk_i);
        end
        drv_en_o <= 1'b0;
        drv_o <= 1'b0;
        @(posedge clk_i);
    endtask

    // samples mid-bit after the falling start edge
    task automatic grab(input int n, input int len, output logic [10:0] bits);
        int w;
        bits = '0;
        w = 0;
        while (line_i !== 1'b0 && w < 20000) begin
            @(posedge clk_i);
            w++;
        end
        repeat (len / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            bits[i] = line_i;
            repeat (len) @(posedge clk_i);
        end
    endtask

    task automatic grab_sync(output logic [7:0] bits);
        for (int i = 0; i < 8; i++) begin
            @(posedge line_i);
            bits[i] = data_i;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/dsp_serial_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port_tb_top;
    import dsp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    int t2_cnt = 0;
    logic [7:0] rdata;
    logic rxd_o, rxd_oe, txd, irq, peer_d, peer_en;
    wire rxd_line = rxd_oe ? rxd_o : (peer_en ? peer_d : 1'b1);
    int err_count = 0;
    int samples_checked = 0;
    logic [10:0] bits;
    logic [7:0] d;
    logic [18:0] rows [9] = '{{3'h2, 8'hA5, 8'hA5}, {3'h3, 8'h3C, 8'h3C}, {3'h4, 8'hC0, 8'hC0},
        {3'h5, 8'h03, 8'h03}, {3'h6, 8'hFF, 8'h00}, {3'h0, 8'h78, 8'h78}, {3'h4, 8'h00, 8'h00},
        {3'h0, 8'hC0, 8'hC0}, {3'h5, 8'h00, 8'h00}};
    // control, frame length, data, ninth or stop bit, receive flag expected
    logic [21:0] filt [8] = '{{8'hF0, 4'hB, 8'hC2, 1'b1, 1'b1}, {8'hF0, 4'hB, 8'hC0, 1'b0, 1'b0},
        {8'hF0, 4'hB, 8'h12, 1'b1, 1'b0}, {8'hF0, 4'hB, 8'hFF, 1'b1, 1'b1},
        {8'hF0, 4'hB, 8'hC1, 1'b1, 1'b0}, {8'h70, 4'hA, 8'hC2, 1'b1, 1'b1},
        {8'h70, 4'hA, 8'hC2, 1'b0, 1'b0}, {8'h70, 4'hA, 8'h12, 1'b1, 1'b0}};

    always #2.5 sys_clk = ~sys_clk;

    // overflow ticks: timer1 every 2 clocks, timer2 every 3
    always @(posedge sys_clk) begin
        t1 <= ~t1;
        t2_cnt <= (t2_cnt == 2) ? 0 : t2_cnt + 1;
        t2 <= (t2_cnt == 2);
    end

    dsp_serial_port i_dsp_serial_port (
        .sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .timer1_ovf_i(t1), .timer2_ovf_i(t2), .rxd_i(rxd_line), .rxd_o(rxd_o),
        .rxd_oe_o(rxd_oe), .txd_o(txd), .irq_o(irq)
    );

    dsp_peer i_dsp_peer (
        .clk_i(sys_clk), .line_i(txd), .data_i(rxd_line), .drv_o(peer_d), .drv_en_o(peer_en)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // second edge keeps back-to-back strobes from landing in one time step
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd_reg(a, v);
        chk({3'h0, v}, {3'h0, exp});
    endtask

    task automatic wait_irq();
        for (int w = 0; w < 400 && irq !== 1'b1; w++) @(posedge sys_clk);
    endtask

    initial begin
        #400000;
        err_count++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({9'h0, txd, irq}, 11'h2);
        for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
        foreach (rows[i]) begin
            wr_reg(rows[i][18:16], rows[i][15:8]);
            rd_chk(rows[i][18:16], rows[i][7:0]);
        end
        wr_reg(ADDR_PWR, 8'h40);
        rd_chk(ADDR_CTRL, 8'h40);
        // full duplex in mode 1: transmit and receive overlap
        wr_reg(ADDR_PWR, 8'h00);
        wr_reg(ADDR_CTRL, 8'h50);
        wr_reg(ADDR_PWR, 8'h40);
        fork
            i_dsp_peer.grab(10, 32, bits);
            wr_reg(ADDR_BUF, 8'hA5);
            i_dsp_peer.send({1'b0, 1'b1, 8'h3C, 1'b0}, 10, 32);
        join
        chk(bits, {1'b0, 1'b1, 8'hA5, 1'b0});
        rd_chk(ADDR_CTRL, 8'h57);
        chk({10'h0, irq}, 11'h1);
        rd_chk(ADDR_BUF, 8'h3C);
        wr_reg(ADDR_CTRL, 8'h50);
        chk({10'h0, irq}, 11'h0);
        // bad stop bit, then a good frame must not clear the error
        i_dsp_peer.send({1'b0, 1'b0, 8'h11, 1'b0}, 10, 32);
        rd_reg(ADDR_CTRL, d);
        chk({10'h0, d[B_MHI]}, 11'h1);
        i_dsp_peer.send({1'b0, 1'b1, 8'h22, 1'b0}, 10, 32);
        rd_reg(ADDR_CTRL, d);
        chk({10'h0, d[B_MHI]}, 11'h1);
        wr_reg(ADDR_CTRL, 8'h40);
        i_dsp_peer.send({1'b0, 1'b1, 8'h33, 1'b0}, 10, 32);
        rd_chk(ADDR_CTRL, 8'h40);
        wr_reg(ADDR_PWR, 8'h00);
        // address filter, receive clock from timer2
        wr_reg(ADDR_STATION_ADDRESS, 8'hC0);
        wr_reg(ADDR_SMASK, 8'hFD);
        wr_reg(ADDR_BAUD, 8'h02);
        foreach (filt[i]) begin
            wr_reg(ADDR_CTRL, filt[i][21:14]);
            if (filt[i][13:10] == BITS_11) begin
                i_dsp_peer.send({1'b1, filt[i][1], filt[i][9:2], 1'b0}, 11, 48);
            end else begin
                i_dsp_peer.send({1'b0, filt[i][1], filt[i][9:2], 1'b0}, 10, 48);
            end
            rd_reg(ADDR_CTRL, d);
            chk({10'h0, d[B_RXDONE]}, {10'h0, filt[i][0]});
        end
        // mode 2 bit lasts 32 clocks with baud_double_select, else 64
        wr_reg(ADDR_PWR, 8'h80);
        wr_reg(ADDR_CTRL, 8'h88);
        fork
            i_dsp_peer.grab(11, 32, bits);
            wr_reg(ADDR_BUF, 8'h5A);
        join
        chk(bits, {1'b1, 1'b1, 8'h5A, 1'b0});
        wait_irq();
        wr_reg(ADDR_PWR, 8'h00);
        wr_reg(ADDR_CTRL, 8'h88);
        fork
            i_dsp_peer.grab(11, 64, bits);
            wr_reg(ADDR_BUF, 8'hC3);
        join
        chk(bits, {1'b1, 1'b1, 8'hC3, 1'b0});
        wait_irq();
        // mode 0 shift out, then shift in with pin held low
        wr_reg(ADDR_CTRL, 8'h00);
        fork
            i_dsp_peer.grab_sync(d);
            wr_reg(ADDR_BUF, 8'h96);
        join
        chk({3'h0, d}, 11'h96);
        wait_irq();
        rd_chk(ADDR_CTRL, 8'h02);
        wr_reg(ADDR_CTRL, 8'h10);
        fork
            i_dsp_peer.send(11'h000, 1, 300);
            wait_irq();
        join
        rd_chk(ADDR_CTRL, 8'h11);
        rd_chk(ADDR_BUF, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
